// [src/pfc_cfg.svh]
// Register map, field positions and reset values of the platform control block.
// Assumes byte addressing on a 32-bit APB with word-aligned registers.
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

`define PFC_ADDR_W 12
`define PFC_OFS_PLAT 12'h00c
`define PFC_OFS_COP 12'h040
`define PFC_OFS_STAT 12'h044

`define PFC_BIT_STALL_EN 16
`define PFC_BIT_SPEC_DIS 15
`define PFC_BIT_DATA_SPEC 14
`define PFC_BIT_WAKE 2
`define PFC_BIT_ACK 1
`define PFC_BIT_REQ 0

`define PFC_PLAT_RST 32'h0000_0000
`define PFC_COP_RST 32'h0000_0000
`define PFC_STALL_CNT_W 16

`endif

// [src/pfc_pkg.sv]
// Types shared by the platform control block.
// Assumes nothing beyond a SystemVerilog tool.
package pfc_pkg;

  typedef enum logic [1:0] {
    cop_idle = 2'b00,
    cop_entering = 2'b01,
    cop_active = 2'b10,
    cop_exiting = 2'b11
  } pfc_cop_state_e;

endpackage

// [src/pfc_op_seq.sv]
// Compute-operation entry and exit sequencer.
// Assumes the platform reports, as a level, that it has reached compute mode.
module pfc_op_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request from the control register
  input wire logic op_req,
  // Platform handshake
  input wire logic op_status,
  output logic op_run,
  // Result
  output logic op_ack,
  output pfc_pkg::pfc_cop_state_e state
);

  pfc_pkg::pfc_cop_state_e next_state;

  always_comb begin
    next_state = state;
    case (state)
      pfc_pkg::cop_idle: begin
        if (op_req) next_state = pfc_pkg::cop_entering;
      end
      pfc_pkg::cop_entering: begin
        if (op_status) next_state = pfc_pkg::cop_active;
        else if (!op_req) next_state = pfc_pkg::cop_idle;
      end
      pfc_pkg::cop_active: begin
        if (!op_req) next_state = pfc_pkg::cop_exiting;
      end
      default: begin
        if (!op_status) next_state = pfc_pkg::cop_idle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state <= pfc_pkg::cop_idle;
    else state <= next_state;
  end

  // Run is asked only while entering or resident
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) op_run <= 1'b0;
    else op_run <= (next_state == pfc_pkg::cop_entering) ||
                   (next_state == pfc_pkg::cop_active);
  end

  // Ack rises once entry is done and holds until exit is done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) op_ack <= 1'b0;
    else op_ack <= (next_state == pfc_pkg::cop_active) ||
                   (next_state == pfc_pkg::cop_exiting);
  end

endmodule // pfc_op_seq

// [src/pfc_ctrl.sv]
// Platform flash and compute-operation control registers behind APB.
// Assumes a flash controller that honours the wait and speculation outputs,
// and a core that pulses vector_fetch on each interrupt or exception fetch.
//
// What this block does
// - Stall enabled: flash busy access gets waits.
// - Same-block fetches stall instead of faulting.
// - Speculation disable bit turns speculation off.
// - Data speculation bit extends speculation to data.
// - Platform bits 13 to 10 read zero.
// - Compute bits 31 to 3 read zero.
// - Wake bit clears request on vector fetch.
// - Ack high between entry done and exit done.
// - Request bit asks for or withdraws operation.
// - Request cleared by hardware only when wake set.
// - Compute register sits at offset 40h.
// - Speculation modes follow the two speculation bits.
// - Only supervisor writes change registers.
// - Both registers reset to zero.
//
// Chosen here: the APB interface to the registers.
`include "pfc_cfg.svh"

module pfc_ctrl #(
  parameter int STALL_CNT_W = `PFC_STALL_CNT_W
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [`PFC_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash controller side
  input wire logic flash_busy,
  input wire logic flash_access,
  output logic spec_instr_en,
  output logic spec_data_en,
  output logic stall_on_flash_busy,
  output logic flash_wait,
  output logic read_collision,
  // Core and platform side
  input wire logic vector_fetch,
  input wire logic cop_status,
  output logic cop_run,
  output logic cop_in_progress
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic access;
  logic do_write;
  logic do_read;
  logic hit_plat;
  logic hit_cop;
  logic hit_stat;
  logic hit_any;
  logic priv;
  logic wr_err;

  // One wait state: pready rises in the second access cycle
  assign access = psel && penable && pready;

  always_comb begin
    hit_plat = 1'b0;
    hit_cop = 1'b0;
    hit_stat = 1'b0;
    if (paddr == `PFC_OFS_PLAT) begin
      hit_plat = 1'b1;
    end else if (paddr == `PFC_OFS_COP) begin
      hit_cop = 1'b1;
    end else if (paddr == `PFC_OFS_STAT) begin
      hit_stat = 1'b1;
    end
  end

  assign hit_any = hit_plat || hit_cop || hit_stat;
  assign priv = pprot[0];
  // User-mode writes are dropped and flagged, like other supervisor-only blocks
  assign wr_err = pwrite && (!priv || hit_stat);
  assign do_write = access && pwrite && priv && (hit_plat || hit_cop);
  assign do_read = access && !pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && penable && !pready && (!hit_any || wr_err);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Platform control register

  logic stall_en;
  logic spec_dis;
  logic data_spec;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_en <= 1'b0;
    end else if (do_write && hit_plat && pstrb[`PFC_BIT_STALL_EN/8]) begin
      stall_en <= pwdata[`PFC_BIT_STALL_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spec_dis <= 1'b0;
      data_spec <= 1'b0;
    end else if (do_write && hit_plat && pstrb[`PFC_BIT_SPEC_DIS/8]) begin
      spec_dis <= pwdata[`PFC_BIT_SPEC_DIS];
      data_spec <= pwdata[`PFC_BIT_DATA_SPEC];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speculation and stall outputs

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spec_instr_en <= 1'b0;
      spec_data_en <= 1'b0;
    end else begin
      spec_instr_en <= !spec_dis;
      spec_data_en <= !spec_dis && data_spec;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_on_flash_busy <= 1'b0;
    end else begin
      stall_on_flash_busy <= stall_en;
    end
  end

  // A busy-flash access is held with wait states when stalling is on, so code
  // in the same block keeps running; otherwise it is reported as a collision.
  // Sector safety stays with software; this logic cannot see sectors.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_wait <= 1'b0;
    end else begin
      flash_wait <= stall_en && flash_busy && flash_access;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_collision <= 1'b0;
    end else begin
      read_collision <= !stall_en && flash_busy && flash_access;
    end
  end

  // Stall cycles seen, saturating, for software diagnosis
  logic [STALL_CNT_W-1:0] stall_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cnt <= '0;
    end else if (do_write && hit_plat && pstrb[`PFC_BIT_STALL_EN/8]) begin
      stall_cnt <= '0;
    end else if (flash_wait && !(&stall_cnt)) begin
      stall_cnt <= stall_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compute operation control register

  logic wake_on_irq;
  logic cop_req;
  logic cop_ack;
  logic req_wr;
  pfc_pkg::pfc_cop_state_e cop_state;

  assign req_wr = do_write && hit_cop && pstrb[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_on_irq <= 1'b0;
    end else if (req_wr) begin
      wake_on_irq <= pwdata[`PFC_BIT_WAKE];
    end
  end

  // A software write in the same cycle as a vector fetch wins, so a fresh
  // request is never lost to an older fetch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cop_req <= 1'b0;
    end else if (req_wr) begin
      cop_req <= pwdata[`PFC_BIT_REQ];
    end else if (wake_on_irq && vector_fetch) begin
      cop_req <= 1'b0;
    end
  end

  pfc_op_seq u_seq (
    .clk(pclk),
    .rst_n(presetn),
    .op_req(cop_req),
    .op_status(cop_status),
    .op_run(cop_run),
    .op_ack(cop_ack),
    .state(cop_state)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cop_in_progress <= 1'b0;
    end else begin
      cop_in_progress <= (cop_state == pfc_pkg::cop_entering) ||
                         (cop_state == pfc_pkg::cop_exiting);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_plat) begin
      next_prdata[`PFC_BIT_STALL_EN] = stall_en;
      next_prdata[`PFC_BIT_SPEC_DIS] = spec_dis;
      next_prdata[`PFC_BIT_DATA_SPEC] = data_spec;
    end else if (hit_cop) begin
      next_prdata[`PFC_BIT_WAKE] = wake_on_irq;
      next_prdata[`PFC_BIT_ACK] = cop_ack;
      next_prdata[`PFC_BIT_REQ] = cop_req;
    end else if (hit_stat) begin
      next_prdata[STALL_CNT_W+3:4] = stall_cnt;
      next_prdata[3:2] = cop_state;
      next_prdata[1] = flash_busy;
      next_prdata[0] = cop_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready && !pwrite) begin
      prdata <= next_prdata;
    end else if (do_read) begin
      prdata <= 32'h0000_0000;
    end
  end

endmodule // pfc_ctrl

// [verif/pfc_ctrl_props.sv]
// Concurrent checks on the ports of the platform control block.
// Assumes one APB slave with one wait state, watched through bind.
module pfc_ctrl_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flash and core
  input wire logic flash_busy,
  input wire logic flash_access,
  input wire logic spec_instr_en,
  input wire logic spec_data_en,
  input wire logic stall_on_flash_busy,
  input wire logic flash_wait,
  input wire logic read_collision,
  input wire logic vector_fetch,
  input wire logic cop_run
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr_cop;
  assign acc = psel && penable && pready;
  assign wr_cop = acc && pwrite && paddr == 12'h040 && pprot[0] && pstrb[0];
  ////////////////////////////////////////////////////////////////////////
  sequence s_one_wait;
    ##1 !pready ##1 pready;
  endsequence
  // Output stall level lags the bit, so two stable cycles pin it down
  sequence s_busy_hit(logic st);
    (flash_busy && flash_access && stall_on_flash_busy == st) ##1 stall_on_flash_busy == st;
  endsequence
  a_ready_wait: assert property (psel && !penable |-> s_one_wait)
    else $error("pready not in second access cycle");
  a_wait_on_busy: assert property (s_busy_hit(1'b1) |-> flash_wait && !read_collision)
    else $error("no wait state while stalling");
  a_no_stall_off: assert property (s_busy_hit(1'b0) |-> read_collision && !flash_wait)
    else $error("stall applied while disabled");
  a_spec_pair: assert property (spec_data_en |-> spec_instr_en)
    else $error("data speculation without instruction speculation");
  a_user_write: assert property (acc && pwrite && !pprot[0] |-> pslverr)
    else $error("user write accepted");
  a_unmapped_err: assert property (
    acc && !(paddr inside {12'h00c, 12'h040, 12'h044}) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_run_on_req: assert property (wr_cop && pwdata[0] |-> ##[1:3] cop_run)
    else $error("request did not start operation");
  a_run_off_req: assert property (wr_cop && !pwdata[0] |-> ##[1:3] !cop_run)
    else $error("withdrawn request kept operation");
  a_fall_cause: assert property (
    $fell(cop_run) |-> $past(wr_cop) || $past(wr_cop, 2)
    || $past(wr_cop, 3) || $past(vector_fetch) || $past(vector_fetch, 2)
    || $past(vector_fetch, 3))
    else $error("request cleared without cause");
endmodule // pfc_ctrl_props

bind pfc_ctrl pfc_ctrl_props u_props (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .pstrb, .pprot, .prdata, .pready, .pslverr, .flash_busy, .flash_access,
  .spec_instr_en, .spec_data_en, .stall_on_flash_busy, .flash_wait, .read_collision,
  .vector_fetch, .cop_run);

// [verif/pfc_plat_model.sv]
// Platform model: enters or leaves compute operation after a set delay.
// Assumes cop_run is a level held for as long as the operation is wanted.
module pfc_plat_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Handshake
  input wire logic run,
  input wire logic [3:0] dly,
  output logic status
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      status <= 1'b0;
    end else if (run == status) begin
      cnt <= 4'h0;
    end else if (cnt >= dly) begin
      status <= run;
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule // pfc_plat_model

// [verif/pfc_ctrl_test.sv]
// Self-checking bench for the platform control block over APB.
// Assumes the platform model answers compute requests.
module pfc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] pprot = 3'h1;
  logic [31:0] prdata;
  logic pready, pslverr, flash_busy = 1'b0, flash_access = 1'b0, vector_fetch = 1'b0;
  logic spec_instr_en, spec_data_en, stall_on_flash_busy, flash_wait, read_collision;
  logic cop_status, cop_run, cop_in_progress;
  logic [3:0] dly = 4'h8;
  int n_fail = 0;
  int checked = 0;
  always #50 pclk = ~pclk;
  pfc_ctrl dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .pprot, .prdata, .pready, .pslverr, .flash_busy, .flash_access, .spec_instr_en,
    .spec_data_en, .stall_on_flash_busy, .flash_wait, .read_collision, .vector_fetch,
    .cop_status, .cop_run, .cop_in_progress);
  pfc_plat_model plat (.clk(pclk), .rst_n(presetn), .run(cop_run), .dly, .status(cop_status));
  ////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] pr,
    input logic xe, output logic [31:0] q);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= pr;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_fail++;
      finish_test();
    end
    q = prdata;
    chk("pslverr", {31'h0, xe}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [2:0] pr, input logic xe);
    logic [31:0] q;
    apb(1'b1, a, d, pr, xe, q);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, 3'h0, xe, q);
    chk("prdata", x, q & m);
  endtask
  // Timeout here counts as a mismatch and ends the run
  task wait_st(input logic v);
    int i;
    i = 0;
    while (cop_status !== v && i < 100) begin
      @(posedge pclk);
      i++;
    end
    if (i >= 100) begin
      n_fail++;
      finish_test();
    end
    repeat (3) @(posedge pclk);
  endtask
  task pulse_fetch;
    @(posedge pclk);
    vector_fetch <= 1'b1;
    @(posedge pclk);
    vector_fetch <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h00c, 32'hffff_ffff, 32'h0, 1'b0);
    rd(12'h040, 32'hffff_ffff, 32'h0, 1'b0);
    rd(12'h010, 32'hffff_ffff, 32'h0, 1'b1);
    rd(12'h044, 32'hffff_ffff, 32'h0, 1'b0);
    wr(12'h044, 32'hffff_ffff, 3'h1, 1'b1);
    wr(12'h040, 32'h5, 3'h0, 1'b1);
    rd(12'h040, 32'hffff_ffff, 32'h0, 1'b0);
    $display("test reset done");
    wr(12'h00c, 32'hffff_ffff, 3'h1, 1'b0);
    rd(12'h00c, 32'hffff_ffff, 32'h0001_c000, 1'b0);
    chk("spec", 32'h0, {30'h0, spec_instr_en, spec_data_en});
    wr(12'h00c, 32'h0000_4000, 3'h1, 1'b0);
    wr(12'h00c, 32'h0, 3'h0, 1'b1);
    rd(12'h00c, 32'hffff_ffff, 32'h0000_4000, 1'b0);
    chk("spec", 32'h3, {30'h0, spec_instr_en, spec_data_en});
    wr(12'h00c, 32'h0, 3'h1, 1'b0);
    repeat (2) @(posedge pclk);
    chk("spec", 32'h2, {30'h0, spec_instr_en, spec_data_en});
    $display("test speculation done");
    wr(12'h00c, 32'h0001_0000, 3'h1, 1'b0);
    flash_busy <= 1'b1;
    flash_access <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("wait", 32'h6, {29'h0, stall_on_flash_busy, flash_wait, read_collision});
    flash_busy <= 1'b0;
    wr(12'h00c, 32'h0, 3'h1, 1'b0);
    flash_busy <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("wait", 32'h1, {29'h0, stall_on_flash_busy, flash_wait, read_collision});
    flash_busy <= 1'b0;
    flash_access <= 1'b0;
    $display("test stall done");
    wr(12'h040, 32'hffff_ffff, 3'h1, 1'b0);
    rd(12'h040, 32'hffff_ffff, 32'h5, 1'b0);
    chk("in_progress", 32'h1, {31'h0, cop_in_progress});
    wait_st(1'b1);
    chk("in_progress", 32'h0, {31'h0, cop_in_progress});
    rd(12'h040, 32'hffff_ffff, 32'h7, 1'b0);
    wr(12'h040, 32'h2, 3'h1, 1'b0);
    rd(12'h040, 32'hffff_ffff, 32'h2, 1'b0);
    wait_st(1'b0);
    rd(12'h040, 32'hffff_ffff, 32'h0, 1'b0);
    $display("test compute done");
    dly <= 4'h1;
    wr(12'h040, 32'h5, 3'h1, 1'b0);
    pulse_fetch();
    rd(12'h040, 32'h5, 32'h4, 1'b0);
    wr(12'h040, 32'h1, 3'h1, 1'b0);
    pulse_fetch();
    rd(12'h040, 32'h1, 32'h1, 1'b0);
    wr(12'h040, 32'h0, 3'h1, 1'b0);
    wait_st(1'b0);
    $display("test wake done");
    finish_test();
  end
endmodule // pfc_ctrl_test
